/* File: core/sbsp_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_regs.svh"

module sbsp_mem (
	// Clock
	input wire logic clk_in,
	input wire logic ce_in,
	// Write port
	input wire logic [`SBSP_LANES-1:0] wr_lanes_in,
	input wire logic [`SBSP_ADDR_W-1:0] wr_addr_in,
	input wire logic [`SBSP_DATA_W-1:0] wr_data_in,
	// Read port
	input wire logic [`SBSP_ADDR_W-1:0] rd_addr_in,
	output logic [`SBSP_DATA_W-1:0] rd_data_out
);

	genvar lane;
	generate
		for (lane = 0; lane < `SBSP_LANES; lane++) begin : g_lane
			logic [`SBSP_LANE_W-1:0] mem [`SBSP_DEPTH];
			logic [`SBSP_LANE_W-1:0] wr_byte;
			logic wr_hit;
			assign wr_byte = wr_data_in[lane*`SBSP_LANE_W +: `SBSP_LANE_W];
			assign wr_hit = wr_lanes_in[lane] && (wr_addr_in == rd_addr_in);
			always_ff @(posedge clk_in) begin
				if (ce_in) begin
					if (wr_lanes_in[lane]) begin
						mem[wr_addr_in] <= wr_byte;
					end
					// Forward a byte written in the same edge
					if (wr_hit) begin
						rd_data_out[lane*`SBSP_LANE_W +: `SBSP_LANE_W] <= wr_byte;
					end else begin
						rd_data_out[lane*`SBSP_LANE_W +: `SBSP_LANE_W] <= mem[rd_addr_in];
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* File: core/sbsp_top.sv */
// Function
// [R1] Store 128K words of 32 bits
// [R2] Two-bit burst counter makes low address bits
// [R3] Register address, data, controls on rising edge
// [R4] Either address strobe starts a burst
// [R5] Order select low linear, high interleaved
// [R6] Writes self-timed from the clock edge
// [R7] Four byte lanes, one write input each
// [R8] Write enable writes only selected lanes
// [R9] Global write or all lanes writes whole word
// [R10] Read data flows from registered address
// [R11] Controller strobe aborts burst, loads new address
// [R12] Processor strobe blocked while primary enable high
// [R13] Burst step advances counter in selected order
// [R14] Output enable gates data drivers, not clocked; code synchronises it in two flops, then registers it into oe_reg
// [R15] Host wires its two address LSBs low
// [R16] Sleep request holds data, waits for access
// [R17] Select needs all three enables, else deselect
// [R18] Linear adds count, interleaved XORs count
// [R19] Drivers off when disabled or writing
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_regs.svh"

module sbsp_top (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	// Synchronous controls and address
	input wire sbsp_pkg::sbsp_ctrl_t CTRL_IN,
	input wire logic [`SBSP_ADDR_W-1:0] ADDR_IN,
	// Asynchronous controls
	input wire sbsp_pkg::sbsp_async_t ASYNC_IN,
	// Data pins
	input wire logic [`SBSP_DATA_W-1:0] DATA_IN,
	output logic [`SBSP_DATA_W-1:0] DATA_OUT,
	output logic DATA_OE_OUT,
	// Status
	output logic SLEEPING_OUT
);

	import sbsp_pkg::*;

	// Asynchronous pin synchronisers
	logic [`SBSP_ASYNC_N-1:0] async_raw;
	logic [`SBSP_ASYNC_N-1:0] meta_reg;
	logic [`SBSP_ASYNC_N-1:0] meta_next;
	logic [`SBSP_ASYNC_N-1:0] sync_reg;
	logic [`SBSP_ASYNC_N-1:0] sync_next;

	assign async_raw = ASYNC_IN;

	genvar bit_i;
	generate
		for (bit_i = 0; bit_i < `SBSP_ASYNC_N; bit_i++) begin : g_sync
			always_comb begin
				meta_next[bit_i] = async_raw[bit_i];
				sync_next[bit_i] = meta_reg[bit_i];
			end
		end
	endgenerate

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			meta_reg <= `SBSP_ASYNC_RST;
			sync_reg <= `SBSP_ASYNC_RST;
		end else if (CE_IN) begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	logic oe_on;
	logic order_interleaved;
	logic sleep_on;

	always_comb begin
		oe_on = !sync_reg[`SBSP_ASYNC_OE];
		order_interleaved = sync_reg[`SBSP_ASYNC_ORDER];
		sleep_on = sync_reg[`SBSP_ASYNC_SLEEP];
	end

	// Cycle state and burst registers
	sbsp_state_t state_reg;
	sbsp_state_t state_next;
	logic [`SBSP_HI_W-1:0] addr_hi_reg;
	logic [`SBSP_HI_W-1:0] addr_hi_next;
	logic [`SBSP_BURST_W-1:0] base_reg;
	logic [`SBSP_BURST_W-1:0] base_next;
	logic [`SBSP_BURST_W-1:0] count_reg;
	logic [`SBSP_BURST_W-1:0] count_next;
	logic [`SBSP_LANES-1:0] lanes_reg;
	logic [`SBSP_LANES-1:0] lanes_next;
	logic [`SBSP_DATA_W-1:0] wdata_reg;
	logic [`SBSP_DATA_W-1:0] wdata_next;
	logic oe_reg;
	logic oe_next;
	logic sleeping_reg;
	logic sleeping_next;

	logic start_proc;
	logic start_ctrl;
	logic selected;
	logic [`SBSP_LANES-1:0] lanes_cmd;
	logic [`SBSP_BURST_W-1:0] low_cur;
	logic [`SBSP_BURST_W-1:0] low_next;

	// Burst sequence from base and count
	function automatic logic [`SBSP_BURST_W-1:0] burst_low(
		input logic [`SBSP_BURST_W-1:0] base,
		input logic [`SBSP_BURST_W-1:0] count,
		input logic interleaved
	);
		logic [`SBSP_BURST_W-1:0] res;
		if (interleaved) begin
			res = base ^ count; // [R5] [R18]
		end else begin
			res = base + count; // [R5] [R18]
		end
		return res;
	endfunction

	always_comb begin
		state_next = state_reg;
		addr_hi_next = addr_hi_reg;
		base_next = base_reg;
		count_next = count_reg;
		lanes_next = `SBSP_LANES_NONE;
		wdata_next = DATA_IN; // [R3]
		// Processor strobe ignored while primary enable is high
		start_proc = !CTRL_IN.proc_addr_strobe_n && !CTRL_IN.primary_chip_sel_n; // [R12]
		start_ctrl = !start_proc && !CTRL_IN.ctrl_addr_strobe_n; // [R11]
		selected = !CTRL_IN.primary_chip_sel_n && CTRL_IN.depth_sel_high
			&& !CTRL_IN.depth_sel_low_n; // [R17]
		if (!CTRL_IN.all_lanes_write_n) begin
			lanes_cmd = `SBSP_LANES_ALL; // [R9]
		end else if (!CTRL_IN.write_enable_n) begin
			lanes_cmd = ~CTRL_IN.byte_lane_write_n; // [R7] [R8] [R9]
		end else begin
			lanes_cmd = `SBSP_LANES_NONE;
		end
		if (start_proc || start_ctrl) begin
			// New address aborts any burst
			addr_hi_next = ADDR_IN[`SBSP_ADDR_W-1:`SBSP_BURST_W]; // [R4] [R11] [R12]
			base_next = ADDR_IN[`SBSP_BURST_W-1:0]; // [R15]
			count_next = `SBSP_COUNT_RST; // [R2]
			if (!selected) begin
				// Sleep persists across a deselect
				if (state_reg != SBSP_SLEEP) begin
					state_next = SBSP_DESEL; // [R17]
				end
			end else if (start_ctrl && lanes_cmd != `SBSP_LANES_NONE) begin
				state_next = SBSP_WRITE; // [R11]
				lanes_next = lanes_cmd;
			end else begin
				// Processor-started cycle always reads first
				state_next = SBSP_READ; // [R4]
			end
		end else begin
			unique case (state_reg)
				SBSP_READ, SBSP_WRITE: begin
					if (!CTRL_IN.burst_step_n) begin
						count_next = count_reg + 2'h1; // [R13]
					end
					lanes_next = lanes_cmd; // [R8]
					if (lanes_cmd != `SBSP_LANES_NONE) begin
						state_next = SBSP_WRITE;
					end else begin
						state_next = SBSP_READ;
					end
				end
				SBSP_DESEL, SBSP_SLEEP: begin
					state_next = state_reg;
				end
			endcase
		end
		if (sleep_on) begin
			state_next = SBSP_SLEEP; // [R16]
			lanes_next = `SBSP_LANES_NONE;
		end
		sleeping_next = (state_next == SBSP_SLEEP); // [R16]
		if (state_next != SBSP_WRITE) begin
			lanes_next = `SBSP_LANES_NONE;
		end
		// Drivers on only for a read with output enable
		oe_next = oe_on && (state_next == SBSP_READ); // [R14] [R19]
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_reg <= SBSP_DESEL;
			addr_hi_reg <= '0;
			base_reg <= `SBSP_COUNT_RST;
			count_reg <= `SBSP_COUNT_RST;
			lanes_reg <= `SBSP_LANES_NONE;
			wdata_reg <= `SBSP_DATA_RST;
			oe_reg <= 1'b0;
			sleeping_reg <= 1'b0;
		end else if (CE_IN) begin
			state_reg <= state_next;
			addr_hi_reg <= addr_hi_next;
			base_reg <= base_next;
			count_reg <= count_next;
			lanes_reg <= lanes_next;
			wdata_reg <= wdata_next;
			oe_reg <= oe_next;
			sleeping_reg <= sleeping_next;
		end
	end

	always_comb begin
		low_cur = burst_low(base_reg, count_reg, order_interleaved); // [R2]
		low_next = burst_low(base_next, count_next, order_interleaved); // [R2] [R13]
	end

	// Array; write lands one edge after capture, read follows next address
	sbsp_mem u_mem (
		.clk_in(CLK_IN),
		.ce_in(CE_IN),
		.wr_lanes_in(lanes_reg), // [R6] [R7]
		.wr_addr_in({addr_hi_reg, low_cur}), // [R1]
		.wr_data_in(wdata_reg),
		.rd_addr_in({addr_hi_next, low_next}), // [R10]
		.rd_data_out(DATA_OUT) // [R10]
	);

	always_comb begin
		DATA_OE_OUT = oe_reg; // [R19]
		SLEEPING_OUT = sleeping_reg;
	end

endmodule

`default_nettype wire

/* File: include/sbsp_pkg.sv */
`include "sbsp_regs.svh"

package sbsp_pkg;

	typedef enum logic [1:0] {
		SBSP_DESEL = `SBSP_ST_DESEL,
		SBSP_READ = `SBSP_ST_READ,
		SBSP_WRITE = `SBSP_ST_WRITE,
		SBSP_SLEEP = `SBSP_ST_SLEEP
	} sbsp_state_t;

	// Clocked control pins, all sampled on the rising edge
	typedef struct packed {
		logic ctrl_addr_strobe_n;
		logic proc_addr_strobe_n;
		logic burst_step_n;
		logic write_enable_n;
		logic all_lanes_write_n;
		logic [`SBSP_LANES-1:0] byte_lane_write_n;
		logic primary_chip_sel_n;
		logic depth_sel_high;
		logic depth_sel_low_n;
	} sbsp_ctrl_t;

	// Asynchronous pins
	typedef struct packed {
		logic sleep_request;
		logic burst_order_select;
		logic output_enable_n;
	} sbsp_async_t;

endpackage

/* File: include/sbsp_regs.svh */
`ifndef SBSP_REGS_SVH
`define SBSP_REGS_SVH

// Array geometry
`define SBSP_ADDR_W 17
`define SBSP_DEPTH 131072
`define SBSP_DATA_W 32
`define SBSP_LANES 4
`define SBSP_LANE_W 8
`define SBSP_BURST_W 2
`define SBSP_HI_W 15

// Cycle state codes, Gray along desel-read-write-sleep
`define SBSP_ST_DESEL 2'b00
`define SBSP_ST_READ 2'b01
`define SBSP_ST_WRITE 2'b11
`define SBSP_ST_SLEEP 2'b10

// Reset values and the all-lanes mask
`define SBSP_COUNT_RST 2'h0
`define SBSP_LANES_NONE 4'h0
`define SBSP_LANES_ALL 4'hf
`define SBSP_DATA_RST 32'h0000_0000

// Asynchronous inputs: output enable, burst order, sleep
`define SBSP_ASYNC_N 3
`define SBSP_ASYNC_OE 0
`define SBSP_ASYNC_ORDER 1
`define SBSP_ASYNC_SLEEP 2
`define SBSP_ASYNC_RST 3'h3

`endif

/* File: verification/sbsp_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_regs.svh"
module sbsp_bench;
	import sbsp_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic ce = 1;
	sbsp_async_t asy = 3'h3;
	sbsp_ctrl_t ctl;
	logic [16:0] adr;
	logic [31:0] din, dout;
	logic oe, slp;
	logic [31:0] mem [logic [16:0]];
	int miscompares = 0;
	int samples_checked = 0;
	always #25 clk = ~clk;
	sbsp_host u_host (.clk_in(clk), .ctrl_out(ctl), .addr_out(adr), .data_out(din));
	sbsp_top uut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .CTRL_IN(ctl), .ADDR_IN(adr), .ASYNC_IN(asy),
		.DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(oe), .SLEEPING_OUT(slp));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	function automatic logic [1:0] lsb(input logic [1:0] b, input logic [1:0] c, input logic ilv);
		return ilv ? (b ^ c) : (b + c);
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] ln);
		for (int i = 0; i < 4; i++)
			if (ln[i])
				o[8*i+:8] = n[8*i+:8];
		return o;
	endfunction
	task automatic one(input sbsp_ctrl_t c, input logic [16:0] a, input logic [31:0] d);
		u_host.beat(c, a, d);
		@(posedge clk);
		#5;
	endtask
	task automatic burst(input logic [16:0] a, input logic prc, input logic [3:0] ln, input logic gw);
		sbsp_ctrl_t c;
		logic [16:0] x;
		logic [31:0] d;
		logic [3:0] e;
		e = gw ? 4'hf : ln;
		for (int k = 0; k < 4; k++) begin
			c = 12'hffa;
			x = {a[16:2], lsb(a[1:0], k[1:0], asy.burst_order_select)};
			d = $urandom;
			if (k == 0 && prc)
				c.proc_addr_strobe_n = 0;
			else if (k == 0)
				c.ctrl_addr_strobe_n = 0;
			else begin
				c.burst_step_n = 0;
				c.primary_chip_sel_n = 1'($urandom);
				c.proc_addr_strobe_n = ~c.primary_chip_sel_n;
			end
			c.all_lanes_write_n = !gw;
			c.write_enable_n = (ln == 4'h0);
			c.byte_lane_write_n = ~ln;
			one(c, x, d);
			if (e != 4'h0)
				mem[x] = merge(mem[x], d, e);
			else begin
				check(dout, mem[x]);
				check(oe, 1'b1);
			end
		end
		one(12'hffa, x, 32'h0);
	endtask
	initial begin
		logic [16:0] a;
		logic [31:0] d;
		sbsp_ctrl_t c;
		void'($urandom(32'h7dee87cd));
		repeat (6) @(negedge clk);
		rst = 0;
		asy.output_enable_n = 0;
		for (int i = 0; i < 30; i++) begin
			a = 17'($urandom);
			@(negedge clk) asy.burst_order_select = 1'($urandom);
			repeat (3) one(12'hffa, a, 32'h0);
			burst(a, 0, 4'h0, 1);
			burst(a, 0, 4'($urandom), 0);
			burst(a, 1'($urandom), 4'h0, 0);
		end
		burst(a, 0, 4'hf, 0);
		burst(a, 0, 4'h0, 0);
		// Read taken on the edge that lands a write
		c = 12'hffa;
		c.ctrl_addr_strobe_n = 0;
		c.all_lanes_write_n = 0;
		d = $urandom;
		one(c, a, d);
		mem[a] = d;
		c.all_lanes_write_n = 1;
		one(c, a, 32'h0);
		check(dout, d);
		// Read start, then one of three deselect forms
		for (int j = 0; j < 3; j++) begin
			c = 12'hffa;
			c.ctrl_addr_strobe_n = 0;
			one(c, a, 32'h0);
			check(oe, 1'b1);
			c.primary_chip_sel_n = (j == 0);
			c.depth_sel_low_n = (j == 1);
			c.depth_sel_high = (j != 2);
			c.proc_addr_strobe_n = (j == 0);
			c.ctrl_addr_strobe_n = (j == 1);
			one(c, a, 32'h0);
			check(oe, 1'b0);
		end
		@(negedge clk) asy.output_enable_n = 1;
		repeat (3) one(12'hffa, a, 32'h0);
		c.depth_sel_high = 1;
		one(c, a, 32'h0);
		check(oe, 1'b0);
		@(negedge clk) asy = 3'h4;
		repeat (4) one(12'hffa, a, 32'h0);
		check(slp, 1'b1);
		one(c, a, 32'h0);
		check(slp, 1'b1);
		@(negedge clk) asy.sleep_request = 0;
		ce = 0;
		// Selected starts that would wake it if not frozen
		repeat (4) one(c, a, 32'h0);
		check(slp, 1'b1);
		@(negedge clk) ce = 1;
		repeat (3) one(12'hffa, a, 32'h0);
		check(slp, 1'b1);
		burst(a, 0, 4'h0, 0);
		check(slp, 1'b0);
		report_and_stop;
	end
endmodule
`default_nettype wire

/* File: verification/sbsp_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_regs.svh"
module sbsp_host (
	// Clock
	input wire logic clk_in,
	// Cycle pins
	output sbsp_pkg::sbsp_ctrl_t ctrl_out,
	output logic [`SBSP_ADDR_W-1:0] addr_out,
	output logic [`SBSP_DATA_W-1:0] data_out
);
	import sbsp_pkg::*;
	initial begin
		ctrl_out = 12'hffa;
		addr_out = 17'h00000;
		data_out = 32'h0000_0000;
	end
	task automatic beat(input sbsp_ctrl_t c, input logic [16:0] a, input logic [31:0] d);
		@(negedge clk_in);
		ctrl_out = c;
		addr_out = a;
		// Released data bus shows a changing pattern
		data_out = (c.all_lanes_write_n && c.write_enable_n) ? ~data_out : d;
	endtask
endmodule
`default_nettype wire

/* File: verification/sbsp_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_regs.svh"
module sbsp_monitor (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	// Inputs
	input wire sbsp_pkg::sbsp_ctrl_t CTRL_IN,
	input wire logic [`SBSP_ADDR_W-1:0] ADDR_IN,
	input wire sbsp_pkg::sbsp_async_t ASYNC_IN,
	input wire logic [`SBSP_DATA_W-1:0] DATA_IN,
	// Outputs
	input wire logic [`SBSP_DATA_W-1:0] DATA_OUT,
	input wire logic DATA_OE_OUT,
	input wire logic SLEEPING_OUT
);
	import sbsp_pkg::*;
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);
	wire logic sel = !CTRL_IN.primary_chip_sel_n && CTRL_IN.depth_sel_high && !CTRL_IN.depth_sel_low_n;
	wire logic ps = !CTRL_IN.proc_addr_strobe_n && !CTRL_IN.primary_chip_sel_n;
	wire logic st = CE_IN && (ps || !CTRL_IN.ctrl_addr_strobe_n);
	wire logic wr = !CTRL_IN.all_lanes_write_n || (!CTRL_IN.write_enable_n && CTRL_IN.byte_lane_write_n != 4'hf);
	// Enable on and sleep off long enough to pass the synchronisers
	sequence ready3;
		(CE_IN && !ASYNC_IN.output_enable_n && !ASYNC_IN.sleep_request)[*3];
	endsequence
	sequence oe_off3;
		(CE_IN && ASYNC_IN.output_enable_n)[*3];
	endsequence
	// Read beat with both strobes unable to start a cycle
	sequence held_beat;
		DATA_OE_OUT && CTRL_IN.ctrl_addr_strobe_n && CTRL_IN.primary_chip_sel_n && !wr;
	endsequence
	AST_WR_OFF: assert property (st && sel && !ps && wr |=> !DATA_OE_OUT)
		else $error("drivers on after write start");
	AST_DESEL: assert property (st && !sel && !SLEEPING_OUT |=> !DATA_OE_OUT)
		else $error("drivers on after deselect");
	AST_OE_GATE: assert property (oe_off3 |=> !DATA_OE_OUT)
		else $error("drivers on while output enable off");
	AST_READ_ON: assert property (ready3 ##0 (st && sel && (ps || !wr) && !SLEEPING_OUT) |=> DATA_OE_OUT)
		else $error("read start without drivers");
	AST_SLEEP_IN: assert property ((CE_IN && ASYNC_IN.sleep_request)[*3] |=> SLEEPING_OUT)
		else $error("sleep not entered");
	AST_SLEEP_KEEP: assert property (SLEEPING_OUT && !(st && sel) |=> SLEEPING_OUT)
		else $error("sleep left without access");
	AST_FREEZE: assert property (!CE_IN |=> $stable(DATA_OUT) && $stable(DATA_OE_OUT) && $stable(SLEEPING_OUT))
		else $error("outputs moved with clock disabled");
	AST_PROC_HELD: assert property (ready3 ##0 held_beat |=> DATA_OE_OUT)
		else $error("blocked processor strobe deselected");
endmodule
bind sbsp_top sbsp_monitor u_mon (.CLK_IN, .RST_IN, .CE_IN, .CTRL_IN, .ADDR_IN, .ASYNC_IN, .DATA_IN,
	.DATA_OUT, .DATA_OE_OUT, .SLEEPING_OUT);
`default_nettype wire
